// ==== src/pbc_pin_mux.sv ====
// Pin multiplexer for port B pin 7 and port C pins 0 to 2
`timescale 1ns/1ps
module pbc_pin_mux (
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  // Pads
  input  wire logic [pbc_pkg::NPINS-1:0] pad_in_i,
  output wire logic [pbc_pkg::NPINS-1:0] pad_out_o,
  output wire logic [pbc_pkg::NPINS-1:0] pad_oe_n_o,
  // GPIO configuration and data
  input  wire logic [pbc_pkg::NPINS-1:0] gpio_dir_out_i,
  input  wire logic [pbc_pkg::NPINS-1:0] gpio_val_i,
  input  wire logic [pbc_pkg::NPINS-1:0] gpio_od_i,
  input  wire logic [pbc_pkg::NPINS-1:0] gpio_os_i,
  output wire logic [pbc_pkg::NPINS-1:0] gpio_in_o,
  // Pin interrupts
  input  wire logic [pbc_pkg::NPINS-1:0] irq_en_i,
  input  wire logic [pbc_pkg::NPINS-1:0] irq_rise_i,
  input  wire logic [pbc_pkg::NPINS-1:0] irq_clr_i,
  output wire logic [pbc_pkg::NPINS-1:0] irq_flag_o,
  // Port C function selects
  input  wire pbc_pkg::pbc_fn_e          pc0_fn_i,
  input  wire pbc_pkg::pbc_fn_e          pc1_fn_i,
  input  wire pbc_pkg::pbc_fn_e          pc2_fn_i,
  // SPI side of the serial channel
  input  wire logic                      spi_master_i,
  input  wire logic                      spi_in_line_ch_one_tx_i,
  output wire logic                      spi_in_line_ch_one_rx_o,
  input  wire logic                      spi_out_line_ch_one_tx_i,
  output wire logic                      spi_out_line_ch_one_rx_o,
  input  wire logic                      spi_clock_ch_one_tx_i,
  output wire logic                      spi_clock_ch_one_rx_o,
  // I2C side of the serial channel
  input  wire logic                      i2c_clock_ch_one_tx_i,
  output wire logic                      i2c_clock_ch_one_rx_o,
  input  wire logic                      i2c_data_ch_one_tx_i,
  output wire logic                      i2c_data_ch_one_rx_o,
  // UART side of the serial channel
  input  wire logic                      uart_tx_ch_one_i,
  output wire logic                      uart_rx_ch_one_o,
  input  wire logic                      uart_request_to_send_ch_one_n_i
);
  import pbc_pkg::*;

  pbc_pad_if pif ();

  logic [NPINS-1:0] smp_q;
  logic [NPINS-1:0] smp_d;
  logic             miso_rx_q;
  logic             miso_rx_d;
  logic             mosi_rx_q;
  logic             mosi_rx_d;
  logic             sck_rx_q;
  logic             sck_rx_d;
  logic             scl_rx_q;
  logic             scl_rx_d;
  logic             sda_rx_q;
  logic             sda_rx_d;
  logic             urx_q;
  logic             urx_d;
  logic [NPINS-1:0] req_en;
  logic [NPINS-1:0] req_val;
  pbc_drv_e         req_mode [NPINS];
  // Marks the first edge after reset, where the pads still show reset values
  logic             rst_dly_q;

  // GPIO defaults for every pad; open-drain wins if both styles are set
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_gpio
      always_comb begin
        if (gpio_od_i[g]) begin
          req_mode[g] = DRV_OD;
        end else if (gpio_os_i[g]) begin
          req_mode[g] = DRV_OS;
        end else begin
          req_mode[g] = DRV_PP;
        end
      end
    end
  endgenerate

  // Pad drive routing: the case on each select picks one source only
  // one source per pad
  always_comb begin
    req_en  = gpio_dir_out_i;
    req_val = gpio_val_i;
    pif.mode = req_mode;
    case (pc0_fn_i)
      FN_SPI: begin
        req_en[PIN_C0]   = ~spi_master_i;
        req_val[PIN_C0]  = spi_in_line_ch_one_tx_i;
        pif.mode[PIN_C0] = DRV_PP;
      end
      FN_I2C: begin
        req_en[PIN_C0]   = 1'b1;
        req_val[PIN_C0]  = i2c_clock_ch_one_tx_i;
        pif.mode[PIN_C0] = DRV_OD;
      end
      FN_UART: begin
        req_en[PIN_C0]   = 1'b1;
        req_val[PIN_C0]  = uart_tx_ch_one_i;
        pif.mode[PIN_C0] = DRV_PP;
      end
      default: ;
    endcase
    case (pc1_fn_i)
      FN_SPI: begin
        req_en[PIN_C1]   = spi_master_i;
        req_val[PIN_C1]  = spi_out_line_ch_one_tx_i;
        pif.mode[PIN_C1] = DRV_PP;
      end
      FN_I2C: begin
        req_en[PIN_C1]   = 1'b1;
        req_val[PIN_C1]  = i2c_data_ch_one_tx_i;
        pif.mode[PIN_C1] = DRV_OD;
      end
      FN_UART: begin
        req_en[PIN_C1]   = 1'b0;
        req_val[PIN_C1]  = 1'b0;
        pif.mode[PIN_C1] = DRV_PP;
      end
      default: ;
    endcase
    // port C pin 2 functions; I2C has no use here and falls back to GPIO
    case (pc2_fn_i)
      FN_SPI: begin
        req_en[PIN_C2]   = spi_master_i;
        req_val[PIN_C2]  = spi_clock_ch_one_tx_i;
        pif.mode[PIN_C2] = DRV_PP;
      end
      FN_UART: begin
        req_en[PIN_C2]   = 1'b1;
        req_val[PIN_C2]  = uart_request_to_send_ch_one_n_i;
        pif.mode[PIN_C2] = DRV_PP;
      end
      default: ;
    endcase
  end

  assign pif.en  = req_en;
  assign pif.val = req_val;

  // Receive routing; an unselected receiver sees its idle level
  // serial inputs gated by select
  always_comb begin
    smp_d     = pad_in_i;
    miso_rx_d = RX_IDLE;
    scl_rx_d  = RX_IDLE;
    mosi_rx_d = RX_IDLE;
    sda_rx_d  = RX_IDLE;
    urx_d     = RX_IDLE;
    sck_rx_d  = RX_IDLE;
    if (pc0_fn_i == FN_SPI && spi_master_i) begin
      miso_rx_d = pad_in_i[PIN_C0];
    end
    if (pc0_fn_i == FN_I2C) begin
      scl_rx_d = pad_in_i[PIN_C0];
    end
    if (pc1_fn_i == FN_SPI && !spi_master_i) begin
      mosi_rx_d = pad_in_i[PIN_C1];
    end
    if (pc1_fn_i == FN_I2C) begin
      sda_rx_d = pad_in_i[PIN_C1];
    end
    if (pc1_fn_i == FN_UART) begin
      urx_d = pad_in_i[PIN_C1];
    end
    if (pc2_fn_i == FN_SPI && !spi_master_i) begin
      sck_rx_d = pad_in_i[PIN_C2];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      smp_q     <= {NPINS{RST_SAMPLE}};
      miso_rx_q <= RX_IDLE;
      scl_rx_q  <= RX_IDLE;
      mosi_rx_q <= RX_IDLE;
      sda_rx_q  <= RX_IDLE;
      urx_q     <= RX_IDLE;
      sck_rx_q  <= RX_IDLE;
      rst_dly_q <= 1'b1;
    end else begin
      smp_q     <= smp_d;
      miso_rx_q <= miso_rx_d;
      scl_rx_q  <= scl_rx_d;
      mosi_rx_q <= mosi_rx_d;
      sda_rx_q  <= sda_rx_d;
      urx_q     <= urx_d;
      sck_rx_q  <= sck_rx_d;
      rst_dly_q <= 1'b0;
    end
  end

  assign pif.smp = smp_q;

  pbc_pad_drv u_drv (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .pif    (pif.drv)
  );

  pbc_edge_irq u_irq (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .irq_en_i   (irq_en_i),
    .irq_rise_i (irq_rise_i),
    .irq_clr_i  (irq_clr_i),
    .pif        (pif.irq)
  );

  assign pad_out_o                = pif.out;
  assign pad_oe_n_o               = pif.oe_n;
  assign gpio_in_o                = smp_q;
  assign irq_flag_o               = pif.flag;
  assign spi_in_line_ch_one_rx_o  = miso_rx_q;
  assign spi_out_line_ch_one_rx_o = mosi_rx_q;
  assign spi_clock_ch_one_rx_o    = sck_rx_q;
  assign i2c_clock_ch_one_rx_o    = scl_rx_q;
  assign i2c_data_ch_one_rx_o     = sda_rx_q;
  assign uart_rx_ch_one_o         = urx_q;

  default clocking cb @(posedge mclk_i); endclocking
  // A synchronous reset leaves its values one edge past release, so skip that edge too
  default disable iff (rst_i || rst_dly_q);

  sequence s_spi_master(logic [1:0] fn);
    fn == FN_SPI && spi_master_i;
  endsequence

  sequence s_spi_slave(logic [1:0] fn);
    fn == FN_SPI && !spi_master_i;
  endsequence

  sequence s_b7_push_pull_out;
    gpio_dir_out_i[PIN_B7] && !gpio_od_i[PIN_B7] && !gpio_os_i[PIN_B7];
  endsequence

  a_gpio_b7_drive: assert property (
    s_b7_push_pull_out |=> !pad_oe_n_o[PIN_B7] && pad_out_o[PIN_B7] == $past(gpio_val_i[PIN_B7]))
    else $error("port B pin 7 output not driven");

  a_gpio_b7_input: assert property (
    !gpio_dir_out_i[PIN_B7] |=> pad_oe_n_o[PIN_B7])
    else $error("port B pin 7 input is driven");

  a_miso_master_in: assert property (
    s_spi_master(pc0_fn_i) |=> pad_oe_n_o[PIN_C0]
      && spi_in_line_ch_one_rx_o == $past(pad_in_i[PIN_C0]))
    else $error("master-in pad not an input in master role");

  a_miso_slave_out: assert property (
    s_spi_slave(pc0_fn_i) |=> !pad_oe_n_o[PIN_C0]
      && pad_out_o[PIN_C0] == $past(spi_in_line_ch_one_tx_i))
    else $error("master-in pad not driven in slave role");

  a_mosi_role_dir: assert property (
    (pc1_fn_i == FN_SPI) |=> pad_oe_n_o[PIN_C1] == !$past(spi_master_i))
    else $error("master-out pad direction wrong for role");

  a_scl_od_sense: assert property (
    (pc0_fn_i == FN_I2C && !i2c_clock_ch_one_tx_i) |=> !pad_oe_n_o[PIN_C0]
      && !pad_out_o[PIN_C0] && i2c_clock_ch_one_rx_o == $past(pad_in_i[PIN_C0]))
    else $error("I2C clock pad not pulled low or not sensed");

  a_scl_release: assert property (
    (pc0_fn_i == FN_I2C && i2c_clock_ch_one_tx_i) |=> pad_oe_n_o[PIN_C0])
    else $error("I2C clock pad not released");

  a_uart_tx_out: assert property (
    (pc0_fn_i == FN_UART) |=> !pad_oe_n_o[PIN_C0] && pad_out_o[PIN_C0] == $past(uart_tx_ch_one_i))
    else $error("UART transmit not on port C pin 0");

  a_uart_rx_in: assert property (
    (pc1_fn_i == FN_UART) |=> pad_oe_n_o[PIN_C1] && uart_rx_ch_one_o == $past(pad_in_i[PIN_C1]))
    else $error("UART receive pad driven or not passed");

  a_rts_drive: assert property (
    (pc2_fn_i == FN_UART) |=> !pad_oe_n_o[PIN_C2]
      && pad_out_o[PIN_C2] == $past(uart_request_to_send_ch_one_n_i))
    else $error("request-to-send not driven on port C pin 2");

  a_sck_slave_in: assert property (
    s_spi_slave(pc2_fn_i) |=> pad_oe_n_o[PIN_C2]
      ##1 (pad_oe_n_o[PIN_C2] || !$past(pc2_fn_i == FN_SPI && !spi_master_i)))
    else $error("SPI clock pad driven in slave role");

  a_rx_idle_unsel: assert property (
    (pc1_fn_i == FN_GPIO) |=> uart_rx_ch_one_o && i2c_data_ch_one_rx_o && spi_out_line_ch_one_rx_o)
    else $error("serial receiver sees a GPIO pad");
endmodule

// ==== inc/pbc_pkg.sv ====
// Shared constants and types for the port B/C pin multiplexer
package pbc_pkg;
  // Number of pads handled and their slots in every per-pin vector
  localparam int unsigned NPINS  = 4;
  localparam int unsigned PIN_B7 = 0;
  localparam int unsigned PIN_C0 = 1;
  localparam int unsigned PIN_C1 = 2;
  localparam int unsigned PIN_C2 = 3;

  // Function select of a port C pad
  typedef enum logic [1:0] {
    FN_GPIO,
    FN_SPI,
    FN_I2C,
    FN_UART
  } pbc_fn_e;

  // Output stage style
  typedef enum logic [1:0] {
    DRV_PP,
    DRV_OD,
    DRV_OS
  } pbc_drv_e;

  // Reset values
  localparam logic RST_PAD_OUT  = 1'b0;
  localparam logic RST_PAD_OE_N = 1'b1;
  localparam logic RST_SAMPLE   = 1'b0;
  localparam logic RST_FLAG     = 1'b0;
  localparam logic RX_IDLE      = 1'b1;
endpackage

// ==== inc/pbc_pad_if.sv ====
// Internal carrier between the pin mux core, pad drivers and edge detectors
`timescale 1ns/1ps
interface pbc_pad_if;
  import pbc_pkg::*;
  logic [NPINS-1:0] en;
  logic [NPINS-1:0] val;
  pbc_drv_e         mode [NPINS];
  logic [NPINS-1:0] out;
  logic [NPINS-1:0] oe_n;
  logic [NPINS-1:0] smp;
  logic [NPINS-1:0] flag;

  modport core (output en, output val, output mode, output smp,
                input out, input oe_n, input flag);
  modport drv  (input en, input val, input mode, output out, output oe_n);
  modport irq  (input smp, output flag);
endinterface

// ==== src/pbc_pad_drv.sv ====
// Registered output stage for every pad: push-pull, open-drain or open-source
`timescale 1ns/1ps
module pbc_pad_drv (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // Drive requests and pad outputs
  pbc_pad_if.drv    pif
);
  import pbc_pkg::*;

  logic [NPINS-1:0] out_q;
  logic [NPINS-1:0] out_d;
  logic [NPINS-1:0] oe_n_q;
  logic [NPINS-1:0] oe_n_d;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      always_comb begin
        out_d[g]  = pif.val[g];
        oe_n_d[g] = ~pif.en[g];
        case (pif.mode[g])
          DRV_OD: begin
            out_d[g]  = 1'b0;
            oe_n_d[g] = ~(pif.en[g] & ~pif.val[g]);
          end
          DRV_OS: oe_n_d[g] = ~(pif.en[g] & pif.val[g]);
          default: oe_n_d[g] = ~pif.en[g];
        endcase
      end

      // An open-drain pad must never source current
      a_od_never_high: assert property (@(posedge mclk_i) disable iff (rst_i)
        (pif.mode[g] == DRV_OD) |=> (oe_n_q[g] || !out_q[g]))
        else $error("open-drain pad driven high");

      a_os_never_low: assert property (@(posedge mclk_i) disable iff (rst_i)
        (pif.mode[g] == DRV_OS && pif.en[g] && !pif.val[g]) |=> oe_n_q[g])
        else $error("open-source pad driven low");
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      out_q  <= {NPINS{RST_PAD_OUT}};
      oe_n_q <= {NPINS{RST_PAD_OE_N}};
    end else begin
      out_q  <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pif.out  = out_q;
  assign pif.oe_n = oe_n_q;
endmodule

// ==== src/pbc_edge_irq.sv ====
// Per-pin edge detectors with sticky interrupt request flags
`timescale 1ns/1ps
module pbc_edge_irq (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  // Per-pin control
  input  wire logic [pbc_pkg::NPINS-1:0] irq_en_i,
  input  wire logic [pbc_pkg::NPINS-1:0] irq_rise_i,
  input  wire logic [pbc_pkg::NPINS-1:0] irq_clr_i,
  // Samples in, flags out
  pbc_pad_if.irq                        pif
);
  import pbc_pkg::*;

  logic [NPINS-1:0] prev_q;
  logic [NPINS-1:0] prev_d;
  logic [NPINS-1:0] flag_q;
  logic [NPINS-1:0] flag_d;
  logic [NPINS-1:0] edge_hit;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      always_comb begin
        edge_hit[g] = irq_en_i[g] & (irq_rise_i[g] ? (pif.smp[g] & ~prev_q[g])
                                                   : (~pif.smp[g] & prev_q[g]));
        prev_d[g]   = pif.smp[g];
        // Set beats clear so an edge in the clearing cycle is kept
        flag_d[g]   = edge_hit[g] | (flag_q[g] & ~irq_clr_i[g]);
      end

      a_edge_sets_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
        edge_hit[g] |=> flag_q[g])
        else $error("pin edge did not raise its flag");

      a_flag_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
        (flag_q[g] && !irq_clr_i[g]) |=> flag_q[g])
        else $error("flag dropped without a clear");
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prev_q <= {NPINS{RST_SAMPLE}};
      flag_q <= {NPINS{RST_FLAG}};
    end else begin
      prev_q <= prev_d;
      flag_q <= flag_d;
    end
  end

  assign pif.flag = flag_q;
endmodule

// ==== bench/pbc_board_model.sv ====
// Board-side model of the four pads: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
module pbc_board_model (
  // Clock
  input  wire logic       mclk_i,
  // Device side of the pads
  input  wire logic [3:0] pad_out_i,
  input  wire logic [3:0] pad_oe_n_i,
  // Board drivers and pull-ups
  input  wire logic [3:0] ext_en_i,
  input  wire logic [3:0] ext_val_i,
  input  wire logic [3:0] pull_up_i,
  // Resolved pad levels
  output logic      [3:0] pad_o
);
  logic [3:0] last_q = 4'h0;

  // I2C lines pulled up
  // A floating pad shows the inverse of its last level, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad_o[i] = (pad_oe_n_i[i] === 1'b0) ? pad_out_i[i] :
                 ext_en_i[i] ? ext_val_i[i] : pull_up_i[i] ? 1'b1 : ~last_q[i];
    end
  end

  always_ff @(posedge mclk_i) begin
    last_q <= pad_o;
  end
endmodule

// ==== bench/pbc_pin_mux_tb.sv ====
// Self-checking bench for the port B/C pin multiplexer
`timescale 1ns/1ps
module pbc_pin_mux_tb;
  import pbc_pkg::*;
  logic       mclk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       chk_on = 1'b0;
  logic [3:0] pad_in_i, pad_out_o, pad_oe_n_o, gpio_in_o, irq_flag_o, pull_up;
  logic [3:0] gpio_dir_out_i = 4'h0, gpio_val_i = 4'h0, gpio_od_i = 4'h0, gpio_os_i = 4'h0;
  logic [3:0] irq_en_i = 4'hf, irq_rise_i = 4'hf, irq_clr_i = 4'h0;
  logic [3:0] ext_en = 4'hf, ext_val = 4'hf;
  pbc_fn_e    pc0_fn_i = FN_GPIO, pc1_fn_i = FN_GPIO, pc2_fn_i = FN_GPIO;
  logic       spi_master_i = 1'b0, min_tx = 1'b0, mout_tx = 1'b0, sclk_tx = 1'b0;
  logic       iclk_tx = 1'b1, idat_tx = 1'b1, utx = 1'b1, req_n = 1'b1;
  logic       min_rx, mout_rx, sclk_rx, iclk_rx, idat_rx, urx;
  logic [3:0] e_out, e_oe_n, e_gin, e_gprev, e_flag;
  logic [5:0] e_rx;
  int         err_total = 0;
  int         num_checks = 0;

  always #20 mclk_i = ~mclk_i;
  assign pull_up = {1'b0, pc1_fn_i == FN_I2C, pc0_fn_i == FN_I2C, 1'b0};

  pbc_pin_mux pbc_pin_mux_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_n_o(pad_oe_n_o), .gpio_dir_out_i(gpio_dir_out_i), .gpio_val_i(gpio_val_i),
    .gpio_od_i(gpio_od_i), .gpio_os_i(gpio_os_i), .gpio_in_o(gpio_in_o),
    .irq_en_i(irq_en_i), .irq_rise_i(irq_rise_i), .irq_clr_i(irq_clr_i),
    .irq_flag_o(irq_flag_o), .pc0_fn_i(pc0_fn_i), .pc1_fn_i(pc1_fn_i), .pc2_fn_i(pc2_fn_i),
    .spi_master_i(spi_master_i), .spi_in_line_ch_one_tx_i(min_tx),
    .spi_in_line_ch_one_rx_o(min_rx), .spi_out_line_ch_one_tx_i(mout_tx),
    .spi_out_line_ch_one_rx_o(mout_rx), .spi_clock_ch_one_tx_i(sclk_tx),
    .spi_clock_ch_one_rx_o(sclk_rx), .i2c_clock_ch_one_tx_i(iclk_tx),
    .i2c_clock_ch_one_rx_o(iclk_rx), .i2c_data_ch_one_tx_i(idat_tx),
    .i2c_data_ch_one_rx_o(idat_rx), .uart_tx_ch_one_i(utx), .uart_rx_ch_one_o(urx),
    .uart_request_to_send_ch_one_n_i(req_n)
  );

  pbc_board_model pbc_board_model_i (
    .mclk_i(mclk_i), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pull_up_i(pull_up), .pad_o(pad_in_i)
  );

  // Returns {oe_n, out} of one output stage
  function automatic logic [1:0] stage(input logic en, input logic v, input logic od,
                                       input logic os);
    if (!en) return 2'b10;
    if (od) return {v, 1'b0};
    if (os) return {~v, 1'b1};
    return {1'b0, v};
  endfunction

  always @(posedge mclk_i) begin : ref_model
    logic [1:0] s [4];
    logic [3:0] edg;
    // plain GPIO stage on every pad
    for (int i = 0; i < 4; i++) begin
      s[i] = stage(gpio_dir_out_i[i], gpio_val_i[i], gpio_od_i[i], gpio_os_i[i]);
    end
    case (pc0_fn_i)
      FN_SPI:  s[1] = stage(!spi_master_i, min_tx, 1'b0, 1'b0);
      FN_I2C:  s[1] = stage(1'b1, iclk_tx, 1'b1, 1'b0);
      FN_UART: s[1] = stage(1'b1, utx, 1'b0, 1'b0);
      default: ;
    endcase
    case (pc1_fn_i)
      FN_SPI:  s[2] = stage(spi_master_i, mout_tx, 1'b0, 1'b0);
      FN_I2C:  s[2] = stage(1'b1, idat_tx, 1'b1, 1'b0);
      FN_UART: s[2] = 2'b10;
      default: ;
    endcase
    // third port C pad, request-to-send passed as is
    case (pc2_fn_i)
      FN_SPI:  s[3] = stage(spi_master_i, sclk_tx, 1'b0, 1'b0);
      FN_UART: s[3] = stage(1'b1, req_n, 1'b0, 1'b0);
      default: ;
    endcase
    // per-pin edge flags, set wins over clear
    edg = irq_en_i & ((irq_rise_i & e_gin & ~e_gprev) | (~irq_rise_i & ~e_gin & e_gprev));
    if (rst_i) begin
      e_oe_n <= 4'hf;
      e_gin <= 4'h0;
      e_gprev <= 4'h0;
      e_flag <= 4'h0;
      e_rx <= 6'h3f;
    end else begin
      e_oe_n <= {s[3][1], s[2][1], s[1][1], s[0][1]};
      e_out <= {s[3][0], s[2][0], s[1][0], s[0][0]};
      e_gin <= pad_in_i;
      e_gprev <= e_gin;
      e_flag <= edg | (e_flag & ~irq_clr_i);
      e_rx <= {(pc0_fn_i == FN_SPI && spi_master_i) ? pad_in_i[1] : 1'b1,
               (pc1_fn_i == FN_SPI && !spi_master_i) ? pad_in_i[2] : 1'b1,
               (pc2_fn_i == FN_SPI && !spi_master_i) ? pad_in_i[3] : 1'b1,
               (pc0_fn_i == FN_I2C) ? pad_in_i[1] : 1'b1,
               (pc1_fn_i == FN_I2C) ? pad_in_i[2] : 1'b1,
               (pc1_fn_i == FN_UART) ? pad_in_i[2] : 1'b1};
    end
  end

  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask

  always @(negedge mclk_i) begin
    if (chk_on) begin
      check({2'b00, pad_oe_n_o}, {2'b00, e_oe_n});
      check({2'b00, pad_out_o & ~e_oe_n}, {2'b00, e_out & ~e_oe_n});
      check({2'b00, gpio_in_o}, {2'b00, e_gin});
      check({2'b00, irq_flag_o}, {2'b00, e_flag});
      check({min_rx, mout_rx, sclk_rx, iclk_rx, idat_rx, urx}, e_rx);
    end
  end

  // Configuration changes now and then so edges and steady states both occur
  task automatic rand_step();
    @(posedge mclk_i);
    if ($urandom_range(0, 3) == 0) begin
      gpio_dir_out_i <= 4'($urandom);
      gpio_od_i <= 4'($urandom);
      gpio_os_i <= 4'($urandom);
      irq_en_i <= 4'($urandom);
      irq_rise_i <= 4'($urandom);
      pc0_fn_i <= pbc_fn_e'($urandom_range(0, 3));
      pc1_fn_i <= pbc_fn_e'($urandom_range(0, 3));
      pc2_fn_i <= pbc_fn_e'($urandom_range(0, 3));
      spi_master_i <= 1'($urandom);
    end
    gpio_val_i <= 4'($urandom);
    ext_en <= 4'($urandom);
    ext_val <= 4'($urandom);
    {min_tx, mout_tx, sclk_tx, iclk_tx, idat_tx, utx, req_n} <= 7'($urandom);
    irq_clr_i <= ($urandom_range(0, 7) == 0) ? 4'($urandom) : 4'h0;
  endtask

  task automatic summarize();
    $display("Checks made %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    summarize();
  end

  // Pads held high through the first reset: rising flags must appear two edges after its release
  initial begin
    void'($urandom(33));
    repeat (2) @(posedge mclk_i);
    chk_on <= 1'b1;
    repeat (18) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3000) rand_step();
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3000) rand_step();
    summarize();
  end
endmodule
